// ### rtl/ipr_map.vh
// Constants for the interrupt prioritizer: register offsets, field positions, codes, timing.
// Assumes an APB master on a 10 MHz clock; included by the design files by bare name.
// Notes on behaviour
// RULE1: input-mode shared pin interrupts unless masked
// RULE2: output mode drives pin from shared mask
// RULE3: remote ack write toggles shared mask
// RULE4: four internal sources, receiver source selectable
// RULE5: global enable gates all but non-maskable
// RULE6: swap and returns set, clear, restore enable
// RULE7: taking an interrupt clears global enable
// RULE8: mask bits zero to four per source
// RULE9: reset sets all five mask bits
// RULE10: masking delays, never discards, requests
// RULE11: highest-priority unmasked request wins each sample
// RULE12: vector is base, zeros, code, zeros
// RULE13: requests sampled on clock falling edges
// RULE14: push address, enable, flags onto twelve-deep stack
// RULE15: two-state internal call honours wait states
// RULE16: non-maskable caught on falling pin edge
// RULE17: remote holds pin low until recognized
// RULE18: direction bit resets to input
// RULE19: pin changes two states after ack
// RULE20: receiver select mapping is configurable
// RULE21: ack in input mode leaves mask alone
`ifndef IPR_MAP_VH
`define IPR_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IPR_ADDR_MASK     12'h000
`define IPR_ADDR_AUX      12'h004
`define IPR_ADDR_BASE     12'h008
`define IPR_ADDR_REMOTE   12'h00c
`define IPR_ADDR_FLAGS    12'h010
`define IPR_ADDR_OPS      12'h014
`define IPR_ADDR_VECTOR   12'h018
`define IPR_ADDR_STACK    12'h01c

// ----------------------------------------------------------------------
// Field positions, mask width and reset value
// ----------------------------------------------------------------------
`define IPR_MASK_W        5
`define IPR_MASK_RST      5'h1f
`define IPR_BIT_SHMASK    3
`define IPR_SEL_LO        5
`define IPR_SEL_HI        6
`define IPR_AUX_GIE       0
`define IPR_AUX_DIR       1
`define IPR_REM_ACK       0
`define IPR_FLG_PIN       0
`define IPR_FLG_GIE       1

// Operation register: [1:0] action, [2] selects return (1) or swap (0), [3] pops on return.
`define IPR_OP_LEAVE      2'h0
`define IPR_OP_CLEAR      2'h1
`define IPR_OP_SET        2'h2
`define IPR_OP_RESTORE    2'h3

// ----------------------------------------------------------------------
// Vector codes
// ----------------------------------------------------------------------
`define IPR_CODE_NMI      3'h7
`define IPR_CODE_RX       3'h1
`define IPR_CODE_TXE      3'h2
`define IPR_CODE_LTA      3'h3
`define IPR_CODE_SHPIN    3'h4
`define IPR_CODE_EXP      3'h5

// Default receiver select mapping: value 0 queue full, 1 word ready, 2 and 3 busy.
`define IPR_RXMAP_DEF     8'ha4

// ----------------------------------------------------------------------
// Stack size and timing
// ----------------------------------------------------------------------
`define IPR_STACK_DEPTH   12
`define IPR_STACK_AW      4
`define IPR_STACK_W       16
`define IPR_ACK_DLY_T     2
`define IPR_CALL_T        2
`define IPR_WAIT_W        2

`endif

// ### rtl/ipr_stack.v
// Twelve-entry return stack for interrupt context words.
// Assumes push and pop are never requested together; read data are registered.
`timescale 1ns/10ps
`default_nettype none
`include "ipr_map.vh"

module ipr_stack (
	input  wire                        mclk,
	input  wire                        rst,
	input  wire                        push,
	input  wire                        pop,
	input  wire [`IPR_STACK_W-1:0]     wdata,
	output reg  [`IPR_STACK_W-1:0]     rdata_q,
	output reg  [`IPR_STACK_AW-1:0]    depth_q
);

	reg [`IPR_STACK_W-1:0] mem [0:`IPR_STACK_DEPTH-1];
	wire full  = (depth_q == `IPR_STACK_DEPTH);
	wire empty = (depth_q == 4'h0);

	// Overflow drops the push rather than wrapping, so older context survives.
	always @(posedge mclk) begin
		if (push && !full)
			mem[depth_q] <= wdata;
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			depth_q <= 4'h0;
			rdata_q <= 16'h0000;
		end else if (push && !full) begin
			depth_q <= depth_q + 4'h1;
			rdata_q <= wdata;
		end else if (pop && !empty) begin
			depth_q <= depth_q - 4'h1;
			rdata_q <= (depth_q > 4'h1) ? mem[depth_q - 4'h2] : 16'h0000;
		end
	end

endmodule // ipr_stack
`default_nettype wire

// ### rtl/ipr_prioritizer.v
// Interrupt prioritizer: sources, masks, global enable, vector, call sequencer, shared pin.
// Assumes an APB master on mclk, synchronous inputs, and a core that drives insn_start.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ipr_map.vh"

module ipr_prioritizer (
	input  wire        mclk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Sources
	input  wire        nmi_n,
	input  wire        tx_queue_empty,
	input  wire        line_turnaround_irq,
	input  wire        expiry_irq,
	input  wire        rx_queue_full,
	input  wire        rx_word_ready,
	input  wire        rx_busy_irq,
	// Shared pin, three signals, oe low while driving
	input  wire        shared_irq_pin_in,
	output wire        shared_irq_pin_out,
	output wire        shared_irq_pin_oe_n,
	// Core handshake
	input  wire        insn_start,
	input  wire [15:0] next_pc,
	input  wire [3:0]  alu_flags,
	input  wire [1:0]  bank_pos,
	input  wire [1:0]  insn_waits,
	output reg         call_active_q,
	output reg         call_take_q,
	output reg  [15:0] vector_q,
	output wire [15:0] stack_top
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg [`IPR_MASK_W-1:0] mask_q;
	reg [1:0]             rx_sel_q;
	reg                   global_irq_en_q;
	reg                   shared_pin_dir_q;
	reg [7:0]             vector_base_q;
	reg [7:0]             rx_map_q;
	reg                   pin_mirror_q;
	reg                   pin_drive_q;
	reg [1:0]             ack_dly_q;
	reg                   nmi_n_neg_q;
	reg                   nmi_prev_q;
	reg                   nmi_pend_q;
	reg [5:0]             req_neg_q;

	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && !pwrite;
	wire hit = (paddr == `IPR_ADDR_MASK) || (paddr == `IPR_ADDR_AUX) ||
		(paddr == `IPR_ADDR_BASE) || (paddr == `IPR_ADDR_REMOTE) ||
		(paddr == `IPR_ADDR_FLAGS) || (paddr == `IPR_ADDR_OPS) ||
		(paddr == `IPR_ADDR_VECTOR) || (paddr == `IPR_ADDR_STACK);

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;

	wire mask_wr   = wr_en && (paddr == `IPR_ADDR_MASK);
	wire aux_wr    = wr_en && (paddr == `IPR_ADDR_AUX);
	wire remote_wr = wr_en && (paddr == `IPR_ADDR_REMOTE);
	wire ops_wr    = wr_en && (paddr == `IPR_ADDR_OPS);
	wire ack_wr    = remote_wr && pwdata[`IPR_REM_ACK];

	// ------------------------------------------------------------------
	// Receiver source selection
	// ------------------------------------------------------------------
	wire [1:0] rx_map_ent = rx_map_q[2*rx_sel_q +: 2];
	reg        rx_src;
	always @* begin
		case (rx_map_ent) // see RULE4 see RULE20
			2'h0:    rx_src = rx_queue_full;
			2'h1:    rx_src = rx_word_ready;
			default: rx_src = rx_busy_irq;
		endcase
	end

	// ------------------------------------------------------------------
	// Falling-edge sampling
	// ------------------------------------------------------------------
	// Priority order index 0..5: nmi, rx, tx empty, turnaround, shared pin, expiry.
	wire shared_req = !shared_pin_dir_q && !shared_irq_pin_in; // see RULE1 see RULE17
	wire [5:0] raw_req = {expiry_irq, shared_req, line_turnaround_irq,
		tx_queue_empty, rx_src, 1'b0};

	// The negedge flops only capture; all decisions stay on the rising edge.
	always @(negedge mclk or posedge rst) begin
		if (rst) begin
			req_neg_q   <= 6'h00;
			nmi_n_neg_q <= 1'b1;
		end else begin
			req_neg_q   <= raw_req; // see RULE13
			nmi_n_neg_q <= nmi_n;
		end
	end

	// ------------------------------------------------------------------
	// Priority resolution
	// ------------------------------------------------------------------
	wire [5:0] enabled;
	assign enabled[0] = nmi_pend_q;
	genvar gi;
	generate
		for (gi = 1; gi < 6; gi = gi + 1) begin : g_en
			// Request stays pending while masked; nothing is latched away.
			assign enabled[gi] = req_neg_q[gi] && !mask_q[gi-1] && global_irq_en_q; // see RULE5 see RULE8 see RULE10
		end
	endgenerate

	reg [2:0] win_code;
	always @* begin
		if (enabled[0])      win_code = `IPR_CODE_NMI; // see RULE11
		else if (enabled[1]) win_code = `IPR_CODE_RX;
		else if (enabled[2]) win_code = `IPR_CODE_TXE;
		else if (enabled[3]) win_code = `IPR_CODE_LTA;
		else if (enabled[4]) win_code = `IPR_CODE_SHPIN;
		else                 win_code = `IPR_CODE_EXP;
	end
	wire any_req = |enabled;

	// ------------------------------------------------------------------
	// Internal call sequencer
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_T1   = 3'b010;
	localparam [2:0] ST_T2   = 3'b100;
	reg [2:0]             state_q;
	reg [`IPR_WAIT_W-1:0] wait_q;

	wire take = (state_q == ST_IDLE) && insn_start && any_req;
	wire [15:0] push_word = {next_pc[15:7], global_irq_en_q, alu_flags, bank_pos};
	wire [3:0]  stk_depth;
	wire [15:0] stk_rdata;

	// Swap and return operations on the global enable.
	wire [1:0] op_act  = pwdata[1:0];
	wire       op_ret  = pwdata[2];
	wire       op_pop  = ops_wr && op_ret && pwdata[3];
	wire       saved_gie = stk_rdata[6];

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q       <= ST_IDLE;
			wait_q        <= 2'h0;
			call_active_q <= 1'b0;
			call_take_q   <= 1'b0;
			vector_q      <= 16'h0000;
		end else begin
			call_take_q <= take;
			case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q       <= ST_T1;
						wait_q        <= insn_waits; // see RULE15
						call_active_q <= 1'b1;
						vector_q      <= {vector_base_q, 3'h0, win_code, 2'h0}; // see RULE12
					end
				end
				ST_T1: begin
					if (wait_q != 2'h0)
						wait_q <= wait_q - 2'h1;
					else
						state_q <= ST_T2;
				end
				ST_T2: begin
					state_q       <= ST_IDLE;
					call_active_q <= 1'b0;
				end
				default: begin
					state_q       <= ST_IDLE;
					call_active_q <= 1'b0;
				end
			endcase
		end
	end

	ipr_stack u_stack (
		.mclk    (mclk),
		.rst     (rst),
		.push    (take), // see RULE14
		.pop     (op_pop),
		.wdata   (push_word),
		.rdata_q (stk_rdata),
		.depth_q (stk_depth)
	);
	assign stack_top = stk_rdata;

	// ------------------------------------------------------------------
	// Non-maskable edge detect
	// ------------------------------------------------------------------
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			nmi_prev_q <= 1'b1;
			nmi_pend_q <= 1'b0;
		end else begin
			nmi_prev_q <= nmi_n_neg_q;
			if (nmi_prev_q && !nmi_n_neg_q)
				nmi_pend_q <= 1'b1; // see RULE16
			else if (take && win_code == `IPR_CODE_NMI)
				nmi_pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			mask_q           <= `IPR_MASK_RST; // see RULE9
			rx_sel_q         <= 2'h0;
			global_irq_en_q  <= 1'b0;
			shared_pin_dir_q <= 1'b0; // see RULE18
			vector_base_q    <= 8'h00;
			rx_map_q         <= `IPR_RXMAP_DEF;
			ack_dly_q        <= 2'h0;
		end else begin
			// The delayed ack toggles the shared mask after the write ends.
			ack_dly_q <= {ack_dly_q[0], ack_wr && shared_pin_dir_q}; // see RULE21
			if (mask_wr) begin
				mask_q   <= pwdata[`IPR_MASK_W-1:0];
				rx_sel_q <= pwdata[`IPR_SEL_HI:`IPR_SEL_LO];
			end
			if (ack_dly_q[1])
				mask_q[`IPR_BIT_SHMASK] <= ~mask_q[`IPR_BIT_SHMASK]; // see RULE3 see RULE19
			if (wr_en && paddr == `IPR_ADDR_BASE)
				vector_base_q <= pwdata[7:0];
			if (wr_en && paddr == `IPR_ADDR_VECTOR)
				rx_map_q <= pwdata[7:0];
			if (aux_wr)
				shared_pin_dir_q <= pwdata[`IPR_AUX_DIR];
			// Recognition wins over any software change in the same cycle.
			if (take)
				global_irq_en_q <= 1'b0; // see RULE7
			else if (aux_wr)
				global_irq_en_q <= pwdata[`IPR_AUX_GIE]; // see RULE5
			else if (ops_wr) begin
				case (op_act) // see RULE6
					`IPR_OP_CLEAR:   global_irq_en_q <= 1'b0;
					`IPR_OP_SET:     global_irq_en_q <= 1'b1;
					`IPR_OP_RESTORE: global_irq_en_q <= op_ret ? saved_gie : global_irq_en_q;
					default:         global_irq_en_q <= global_irq_en_q;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Shared pin drive and mirror
	// ------------------------------------------------------------------
	// Pin and mirror update at each instruction start, as with T1.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_drive_q  <= 1'b1;
			pin_mirror_q <= 1'b1;
		end else if (insn_start) begin
			pin_drive_q  <= mask_q[`IPR_BIT_SHMASK]; // see RULE2
			pin_mirror_q <= shared_pin_dir_q ? pin_drive_q : shared_irq_pin_in; // see RULE2
		end
	end
	assign shared_irq_pin_out  = pin_drive_q;
	assign shared_irq_pin_oe_n = !shared_pin_dir_q;

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always @* begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				`IPR_ADDR_MASK:   prdata = {25'h0, rx_sel_q, mask_q};
				`IPR_ADDR_AUX:    prdata = {30'h0, shared_pin_dir_q, global_irq_en_q};
				`IPR_ADDR_BASE:   prdata = {24'h0, vector_base_q};
				`IPR_ADDR_REMOTE: prdata = {31'h0, mask_q[`IPR_BIT_SHMASK]}; // see RULE3
				`IPR_ADDR_FLAGS:  prdata = {30'h0, global_irq_en_q, pin_mirror_q};
				`IPR_ADDR_OPS:    prdata = {28'h0, stk_depth};
				`IPR_ADDR_VECTOR: prdata = {vector_q, 8'h00, rx_map_q};
				`IPR_ADDR_STACK:  prdata = {16'h0, stk_rdata};
				default:          prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule // ipr_prioritizer
`default_nettype wire

// ### test/ipr_remote.sv
// Remote host model on the shared interrupt pin.
// Assumes a pull-up on the pin and a bench that raises req to ask for service.
`timescale 1ns/10ps
`default_nettype none
module ipr_remote (
	input  wire logic        mclk,
	input  wire logic        req,
	input  wire logic        pin_out,
	input  wire logic        pin_oe_n,
	input  wire logic        call_take_q,
	input  wire logic [15:0] vector_q,
	output var  logic        pin_in
);
	logic held = 1'b0;
	logic req_q = 1'b0;
	// The pin is wired-low: a released pin floats up to the pull-up level.
	assign pin_in = (pin_oe_n | pin_out) & ~held;
	always @(posedge mclk) begin
		req_q <= req;
		// Releasing on recognition, or when req drops, avoids a lost or repeated request.
		if (!req || (call_take_q && vector_q[4:2] == 3'h4)) begin
			held <= 1'b0;
		end else if (!req_q) begin
			held <= 1'b1;
		end
	end
endmodule // ipr_remote
`default_nettype wire

// ### test/ipr_prio_assertions.sv
// Port checker for the interrupt prioritizer.
// Assumes it is bound to ipr_prioritizer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ipr_prio_chk (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        insn_start,
	input wire logic        shared_irq_pin_oe_n,
	input wire logic        call_active_q,
	input wire logic        call_take_q,
	input wire logic [15:0] vector_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_BUS_READY: assert property (pready) else $error("pready low");
	AST_BUS_ERR: assert property (psel && penable |->
		pslverr == (paddr > 12'h01c || paddr[1:0] != 2'h0))
		else $error("pslverr wrong");
	AST_TAKE_PULSE: assert property (call_take_q |=> !call_take_q)
		else $error("take not a pulse");
	AST_TAKE_CALL: assert property (call_take_q |-> call_active_q)
		else $error("take without call");
	AST_CALL_MIN: assert property ($rose(call_active_q) |-> call_active_q[*2])
		else $error("call too short");
	AST_CALL_MAX: assert property ($rose(call_active_q) |-> ##[2:5] !call_active_q)
		else $error("call too long");
	AST_CALL_CAUSE: assert property ($rose(call_active_q) |-> $past(insn_start))
		else $error("call without decision point");
	AST_VEC_FORM: assert property (call_take_q |-> vector_q[7:5] == 3'h0 &&
		vector_q[1:0] == 2'h0 && vector_q[4:2] != 3'h0 && vector_q[4:2] != 3'h6)
		else $error("vector malformed");
	AST_VEC_HOLD: assert property (call_active_q && $past(call_active_q) |-> $stable(vector_q))
		else $error("vector moved in call");
	AST_DIR_WRITE: assert property ($fell(shared_irq_pin_oe_n) |->
		$past(psel && penable && pwrite && paddr == 12'h004 && pwdata[1]))
		else $error("pin driven without direction write");
endmodule // ipr_prio_chk
bind ipr_prioritizer ipr_prio_chk i_ipr_prio_chk (.*);
`default_nettype wire

// ### test/tb_ipr_prioritizer.sv
// Self-checking bench for the interrupt prioritizer.
// Assumes the remote host model and the bound checker beside the design.
`timescale 1ns/10ps
`default_nettype none
`include "ipr_map.vh"
module tb_ipr_prioritizer;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, nmi_n = 1;
	logic tx_queue_empty = 0, line_turnaround_irq = 0, expiry_irq = 0, sh_req = 0;
	logic rx_queue_full = 0, rx_word_ready = 0, rx_busy_irq = 0, insn_start = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic [15:0] next_pc = 0, vector_q, stack_top;
	logic [3:0]  alu_flags = 4'ha;
	logic [1:0]  bank_pos = 2'h2, insn_waits = 2'h1, sel;
	logic pready, pslverr, shared_irq_pin_in, shared_irq_pin_out, shared_irq_pin_oe_n;
	logic call_active_q, call_take_q, seen, rerr;
	logic [6:0] rq;
	logic [4:0] msk;
	logic [2:0] code;
	logic [7:0] base;
	int i, checks = 0, n_errors = 0;
	// Row: rx select, requests {expiry, shared, turnaround, tx, busy, word, full}, masks, code.
	logic [16:0] rows [11] = '{{2'h0, 7'h79, 5'h00, 3'h1}, {2'h0, 7'h78, 5'h00, 3'h2},
		{2'h0, 7'h70, 5'h00, 3'h3}, {2'h0, 7'h60, 5'h00, 3'h4}, {2'h0, 7'h40, 5'h00, 3'h5},
		{2'h0, 7'h79, 5'h07, 3'h4}, {2'h0, 7'h79, 5'h1f, 3'h0}, {2'h0, 7'h40, 5'h0f, 3'h5},
		{2'h1, 7'h02, 5'h00, 3'h1}, {2'h2, 7'h04, 5'h00, 3'h1}, {2'h0, 7'h02, 5'h00, 3'h0}};
	ipr_prioritizer i_ipr_prioritizer (.*);
	ipr_remote i_ipr_remote (.mclk(mclk), .req(sh_req), .pin_out(shared_irq_pin_out),
		.pin_oe_n(shared_irq_pin_oe_n), .call_take_q(call_take_q), .vector_q(vector_q),
		.pin_in(shared_irq_pin_in));
	always #50 mclk = ~mclk;
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			final_report();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// Offers one decision point, then waits out any call it caused.
	task automatic start;
		int n;
		seen = 1'b0;
		insn_start <= 1'b1;
		@(posedge mclk);
		insn_start <= 1'b0;
		for (n = 0; n < 5 && !seen; n++) begin
			@(posedge mclk);
			seen = (call_take_q === 1'b1);
		end
		for (n = 0; call_active_q !== 1'b0; n++) begin
			if (n > 8) begin
				n_errors++;
				final_report();
			end
			@(posedge mclk);
		end
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 11; i++) begin
			{sel, rq, msk, code} = rows[i];
			base = 8'hc0 + 8'(i);
			apb(1'b1, `IPR_ADDR_MASK, {25'h0, sel, msk});
			apb(1'b1, `IPR_ADDR_AUX, 32'h1);
			apb(1'b1, `IPR_ADDR_BASE, {24'h0, base});
			{expiry_irq, sh_req, line_turnaround_irq, tx_queue_empty} <= rq[6:3];
			{rx_busy_irq, rx_word_ready, rx_queue_full} <= rq[2:0];
			next_pc <= {8'(i), 8'h9d};
			repeat (3) @(posedge mclk);
			start();
			chk("taken", {31'h0, code != 3'h0}, {31'h0, seen});
			if (code != 3'h0) begin
				chk("vector", {16'h0, base, 3'h0, code, 2'h0}, {16'h0, vector_q});
				chk("stack", {16'h0, next_pc[15:7], 1'b1, alu_flags, bank_pos},
					{16'h0, stack_top});
				apb(1'b0, `IPR_ADDR_FLAGS, 32'h0);
				chk("enable", 32'h0, rdata & 32'h2);
				apb(1'b1, `IPR_ADDR_OPS, 32'hf);
				apb(1'b0, `IPR_ADDR_FLAGS, 32'h0);
				chk("restored", 32'h2, rdata & 32'h2);
			end
			{expiry_irq, sh_req, line_turnaround_irq, tx_queue_empty} <= 4'h0;
			{rx_busy_irq, rx_word_ready, rx_queue_full} <= 3'h0;
			$display("row %0d done", i);
		end
		apb(1'b0, `IPR_ADDR_OPS, 32'h0);
		chk("stack depth", 32'h0, rdata & 32'hf);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		apb(1'b0, `IPR_ADDR_MASK, 32'h0);
		chk("mask reset", 32'h1f, rdata & 32'h1f);
		apb(1'b0, `IPR_ADDR_AUX, 32'h0);
		chk("aux reset", 32'h0, rdata & 32'h3);
		chk("pin dir", 32'h1, {31'h0, shared_irq_pin_oe_n});
		apb(1'b1, `IPR_ADDR_MASK, 32'h0);
		rx_queue_full <= 1'b1;
		repeat (3) @(posedge mclk);
		start();
		chk("gated", 32'h0, {31'h0, seen});
		apb(1'b1, `IPR_ADDR_AUX, 32'h1);
		start();
		chk("late take", 32'h1, {31'h0, seen});
		rx_queue_full <= 1'b0;
		apb(1'b1, `IPR_ADDR_OPS, 32'hc);
		nmi_n <= 1'b0;
		repeat (3) @(posedge mclk);
		start();
		chk("nmi", 32'h1c, {27'h0, vector_q[4:0]});
		nmi_n <= 1'b1;
		start();
		chk("nmi once", 32'h0, {31'h0, seen});
		apb(1'b1, `IPR_ADDR_OPS, 32'hc);
		$display("reset, enable and nmi tests done");
		apb(1'b1, `IPR_ADDR_REMOTE, 32'h1);
		apb(1'b0, `IPR_ADDR_REMOTE, 32'h0);
		chk("ack ignored", 32'h0, rdata & 32'h1);
		apb(1'b1, `IPR_ADDR_MASK, 32'h17);
		apb(1'b1, `IPR_ADDR_AUX, 32'h2);
		start();
		start();
		chk("pin low", 32'h0, {31'h0, shared_irq_pin_out});
		apb(1'b0, `IPR_ADDR_FLAGS, 32'h0);
		chk("mirror", 32'h0, rdata & 32'h1);
		apb(1'b1, `IPR_ADDR_REMOTE, 32'h1);
		apb(1'b0, `IPR_ADDR_REMOTE, 32'h0);
		chk("ack toggle", 32'h1, rdata & 32'h1);
		start();
		chk("pin high", 32'h1, {31'h0, shared_irq_pin_out});
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rerr});
		$display("shared pin tests done");
		final_report();
	end
endmodule // tb_ipr_prioritizer
`default_nettype wire
